/* hw/charge_config_pkg.sv */
`default_nettype none
package charge_config_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CHARGE_CONFIG_LOW_ADDR = 8'h00;
  localparam logic [7:0] CHARGE_CONFIG_LOW_RESET = 8'h0e;
  localparam int RESERVED_BIT = 7;
  localparam int SHORT_HICCUP_OFF_BIT = 6;
  localparam int LEARN_MODE_BIT = 5;
  localparam int INPUT_GAIN_BIT = 4;
  localparam int BATTERY_GAIN_BIT = 3;
  localparam int LINEAR_MODE_BIT = 2;
  localparam int INPUT_LOOP_BIT = 1;
  localparam int CHARGE_BLOCK_BIT = 0;

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  typedef struct packed {
    logic short_hiccup_off;
    logic learn_mode_on;
    logic battery_switch_on;
    logic switching_stop;
    logic input_sense_gain_sel;
    logic battery_sense_gain_sel;
    logic switch_linear_mode_on;
    logic input_limit_loop_on;
    logic charge_block;
  } charge_ctrl_t;
endpackage : charge_config_pkg
`default_nettype wire

/* hw/charge_config_low_byte_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module charge_config_low_byte_regs
  import charge_config_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output var charge_ctrl_t ctrl_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  charge_ctrl_t ctrl_reg;
  charge_ctrl_t ctrl_next;
  logic hit;
  logic write_hit;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  // One decode serves the running outputs and their reset value, so the two cannot drift apart.
  function automatic charge_ctrl_t decode_ctrl(input logic [7:0] byte_value);
    charge_ctrl_t result;
    result.short_hiccup_off = byte_value[SHORT_HICCUP_OFF_BIT];
    result.learn_mode_on = byte_value[LEARN_MODE_BIT];
    result.battery_switch_on = byte_value[LEARN_MODE_BIT];
    result.switching_stop = byte_value[LEARN_MODE_BIT];
    result.input_sense_gain_sel = byte_value[INPUT_GAIN_BIT];
    result.battery_sense_gain_sel = byte_value[BATTERY_GAIN_BIT];
    result.switch_linear_mode_on = byte_value[LINEAR_MODE_BIT];
    result.input_limit_loop_on = byte_value[INPUT_LOOP_BIT];
    result.charge_block = byte_value[CHARGE_BLOCK_BIT];
    return result;
  endfunction : decode_ctrl

  localparam charge_ctrl_t CTRL_RESET = decode_ctrl(CHARGE_CONFIG_LOW_RESET);

  // The write port sits in the clock domain, so no synchroniser is needed.
  assign hit = (reg_addr_in == CHARGE_CONFIG_LOW_ADDR);
  assign write_hit = reg_write_in && hit;

  // ----------------------------------------
  // Stored byte
  // ----------------------------------------
  // Bit 7 is stored as written; keeping it intact is the host's duty.
  always_comb
  begin
    config_next = config_reg;
    if (write_hit)
    begin
      config_next = reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      config_reg <= CHARGE_CONFIG_LOW_RESET;
    end
    else
    begin
      config_reg <= config_next;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data follows the byte as it stands after this edge, so a write is seen at once.
  always_comb
  begin
    rdata_next = hit ? config_next : 8'h00;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_reg <= CHARGE_CONFIG_LOW_RESET;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  // Outputs are a registered copy so that each output comes from a flip-flop.
  always_comb
  begin
    ctrl_next = decode_ctrl(config_next);
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign ctrl_out = ctrl_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_write;
    write_hit;
  endsequence

  sequence s_idle;
    !write_hit;
  endsequence

  sequence s_read_hit;
    hit && !reg_write_in;
  endsequence

  sequence s_miss;
    !hit;
  endsequence

  chk_write_takes_effect: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> (config_reg == $past(reg_wdata_in)))
    else $error("Write not stored.");
  chk_reserved_kept: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_idle |=> $stable(config_reg[RESERVED_BIT]))
    else $error("Reserved bit changed without write.");
  chk_hiccup_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ctrl_out.short_hiccup_off == config_reg[SHORT_HICCUP_OFF_BIT])
    else $error("Hiccup output mismatch.");
  chk_learn_mode: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ctrl_out.learn_mode_on |-> (ctrl_out.battery_switch_on && ctrl_out.switching_stop))
    else $error("Learn mode incomplete.");
  chk_input_gain: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> ctrl_out.input_sense_gain_sel == $past(reg_wdata_in[INPUT_GAIN_BIT]))
    else $error("Input gain not updated.");
  chk_battery_gain: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> ctrl_out.battery_sense_gain_sel == $past(reg_wdata_in[BATTERY_GAIN_BIT]))
    else $error("Battery gain not updated.");
  chk_linear_mode: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ctrl_out.switch_linear_mode_on == config_reg[LINEAR_MODE_BIT])
    else $error("Linear mode mismatch.");
  chk_input_loop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> ctrl_out.input_limit_loop_on == $past(reg_wdata_in[INPUT_LOOP_BIT]))
    else $error("Input loop not updated.");
  chk_charge_block: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_idle |=> $stable(ctrl_out.charge_block))
    else $error("Charge block changed without write.");
  chk_reset_value: assert property (@(posedge clk_in)
    $rose(reset_n_in) |-> config_reg == CHARGE_CONFIG_LOW_RESET)
    else $error("Reset value wrong.");
  chk_read_back: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (hit && !reg_write_in) |=> reg_rdata_out == config_reg)
    else $error("Read value wrong.");

  // Each control output must follow its bit on a write and stand still between writes; battery_switch_on and switching_stop follow the learn mode bit.
  chk_write_read_data: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> reg_rdata_out == $past(reg_wdata_in))
    else $error("Read data missed the write.");
  chk_read_after_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write ##1 s_read_hit |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("Read after write wrong.");
  chk_outputs_stand: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write ##1 s_idle |=> $stable(ctrl_out))
    else $error("Outputs moved without write.");
  chk_unmapped_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_miss |=> reg_rdata_out == 8'h00)
    else $error("Unmapped read not zero.");
  chk_unmapped_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (reg_write_in && !hit) |=> $stable(config_reg))
    else $error("Unmapped write changed the byte.");
  chk_reserved_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> config_reg[RESERVED_BIT] == $past(reg_wdata_in[RESERVED_BIT]))
    else $error("Reserved bit not stored.");
  chk_hiccup_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> ctrl_out.short_hiccup_off == $past(reg_wdata_in[SHORT_HICCUP_OFF_BIT]))
    else $error("Hiccup output not updated.");
  chk_hiccup_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_idle |=> $stable(ctrl_out.short_hiccup_off))
    else $error("Hiccup output changed without write.");
  chk_learn_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> ctrl_out.learn_mode_on == $past(reg_wdata_in[LEARN_MODE_BIT]))
    else $error("Learn mode not updated.");
  chk_learn_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !ctrl_out.learn_mode_on |-> (!ctrl_out.battery_switch_on && !ctrl_out.switching_stop))
    else $error("Learn mode actions without learn mode.");
  chk_input_gain_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_idle |=> $stable(ctrl_out.input_sense_gain_sel))
    else $error("Input gain changed without write.");
  chk_battery_gain_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_idle |=> $stable(ctrl_out.battery_sense_gain_sel))
    else $error("Battery gain changed without write.");
  chk_linear_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> ctrl_out.switch_linear_mode_on == $past(reg_wdata_in[LINEAR_MODE_BIT]))
    else $error("Linear mode not updated.");
  chk_input_loop_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_idle |=> $stable(ctrl_out.input_limit_loop_on))
    else $error("Input loop changed without write.");
  chk_charge_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write |=> ctrl_out.charge_block == $past(reg_wdata_in[CHARGE_BLOCK_BIT]))
    else $error("Charge block not updated.");
  chk_reset_outputs: assert property (@(posedge clk_in)
    $rose(reset_n_in) |-> (ctrl_out == CTRL_RESET && reg_rdata_out == CHARGE_CONFIG_LOW_RESET))
    else $error("Reset outputs wrong.");
endmodule : charge_config_low_byte_regs
`default_nettype wire

/* testbench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic write_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    addr_out = 8'h00;
    write_out = 1'b0;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    write_out <= 1'b1;
    wdata_out <= d;
    @(posedge clk_in);
    write_out <= 1'b0;
    wdata_out <= ~d;
    // Let the stored byte reach the outputs before the caller looks at them.
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask : rd
  // Bit 7 is read back first so that its stored value is written unchanged.
  task automatic set(input logic [6:0] v);
    logic [7:0] cur;
    rd(8'h00, cur);
    wr(8'h00, {cur[7], v});
  endtask : set
endmodule : host_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import charge_config_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr, wdata, rdata, v;
  logic wr;
  charge_ctrl_t ctrl;
  int n_errors = 0;
  int checked = 0;
  always #10 clk_in = ~clk_in;
  host_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .write_out(wr),
    .wdata_out(wdata));
  charge_config_low_byte_regs dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_write_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .ctrl_out(ctrl));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask : check
  function automatic charge_ctrl_t exp_ctrl(input logic [7:0] b);
    return {b[6], b[5], b[5], b[5], b[4], b[3], b[2], b[1], b[0]};
  endfunction : exp_ctrl
  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic test_reset();
    check(ctrl, exp_ctrl(CHARGE_CONFIG_LOW_RESET));
    host.rd(8'h00, v);
    check({1'b0, v}, 9'h00e);
  endtask : test_reset
  // Walking one covers every control bit alone, each written and read back.
  task automatic test_bits();
    for (int i = 0; i < 7; i++)
    begin
      host.set(7'(1 << i));
      check(ctrl, exp_ctrl(8'(1 << i)));
      host.rd(8'h00, v);
      check({1'b0, v}, 9'(1 << i));
    end
  endtask : test_bits
  task automatic test_unmapped();
    host.wr(8'h05, 8'hff);
    check(ctrl, exp_ctrl(8'h40));
    host.rd(8'h05, v);
    check({1'b0, v}, 9'h000);
  endtask : test_unmapped
  // The host keeps bit 7 as it reads it, so setting all other bits leaves it at zero.
  task automatic test_reserved();
    host.set(7'h7f);
    check(ctrl, exp_ctrl(8'h7f));
    host.rd(8'h00, v);
    check({1'b0, v}, 9'h07f);
  endtask : test_reserved
  task automatic test_mid_reset();
    host.set(7'h35);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check(ctrl, exp_ctrl(CHARGE_CONFIG_LOW_RESET));
    check({1'b0, rdata}, {1'b0, CHARGE_CONFIG_LOW_RESET});
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    test_reset();
  endtask : test_mid_reset
  initial
  begin
    #100000;
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    test_reset();
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    test_reset();
    test_bits();
    test_unmapped();
    test_reserved();
    test_mid_reset();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
